// file: hw/rbpc_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes write and read run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rbpc_fifo
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
)
(
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i,
  output var  logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign in_ready_o  = (count != AW'(0) + (AW+1)'(DEPTH)) || do_rd;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign do_rd       = out_valid_o && out_ready_i;
  assign do_wr       = in_valid_i && in_ready_o;

  always_ff @(posedge clock_i)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

endmodule : rbpc_fifo

`default_nettype wire

// file: hw/rbpc_pkg.sv
/*
  Package for the registered command/address buffer with parity check.
  Holds widths, mode encodings, parity masks and reset values.
  Assumes a single clock domain and an active-high asynchronous reset.
*/
package rbpc_pkg;

  localparam int unsigned DATA_W       = 25;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned ERR_HOLD     = 2;
  localparam logic [1:0]  ERR_HOLD_CNT = 2'h2;

  // Parity masks: bit k stands for data input k+1.
  localparam logic [24:0] MASK_SINGLE  = 25'h1ffffb6;
  localparam logic [24:0] MASK_PAIR_A  = 25'h0003fb6;
  localparam logic [24:0] MASK_PAIR_B  = 25'h0001bbf;

  localparam logic [24:0] DATA_RST     = 25'h0000000;
  localparam logic        PPO_RST      = 1'h0;
  localparam logic        ERR_N_RST    = 1'h1;

  typedef enum logic [1:0]
  {
    RBPC_MODE_SINGLE,
    RBPC_MODE_PAIR_A,
    RBPC_MODE_PAIR_B,
    RBPC_MODE_BAD
  } rbpc_mode_e;

endpackage : rbpc_pkg

// file: hw/rbpc_top.sv
/*
  Registered command/address buffer with parity check.
  Assumes inputs arrive from another domain and are synchronised here;
  the configuration inputs are held static by the board.
*/
`timescale 1ns/1ps
`default_nettype none

module rbpc_top
  import rbpc_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] cmd_addr_in_i,
  input  wire logic             chip_select_main_n_i,
  input  wire logic             chip_select_rank_n_i,
  input  wire logic             term_ctrl_in_i,
  input  wire logic             clk_enable_in_i,
  input  wire logic             parity_bit_in_i,
  input  wire logic             pair_select_cfg_i,
  input  wire logic             width_select_cfg_i,
  input  wire logic             out_ready_i,
  output var  logic             in_ready_o,
  output var  logic [WIDTH-1:0] cmd_addr_out_o,
  output var  logic             select_out_o,
  output var  logic             term_ctrl_out_o,
  output var  logic             clk_enable_out_o,
  output var  logic             partial_parity_out_o,
  output var  logic             parity_error_n_o,
  output var  logic             parity_error_n_oe_o
);

  //****************************************************************
  // Input synchronisers
  //****************************************************************
  localparam int unsigned SW = WIDTH + 7;

  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [WIDTH-1:0] d_s;
  logic cs_main_s;
  logic cs_rank_s;
  logic term_s;
  logic cke_s;
  logic par_s;
  logic pair_s;
  logic width_s;

  // Every pin but out_ready_i, configuration included, passes two flops, which costs two
  // cycles of latency on those paths but keeps metastability out.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {width_select_cfg_i, pair_select_cfg_i, parity_bit_in_i,
                clk_enable_in_i, term_ctrl_in_i, chip_select_rank_n_i,
                chip_select_main_n_i, cmd_addr_in_i};
      sync2 <= sync1;
    end
  end

  assign d_s       = sync2[WIDTH-1:0];
  assign cs_main_s = sync2[WIDTH];
  assign cs_rank_s = sync2[WIDTH+1];
  assign term_s    = sync2[WIDTH+2];
  assign cke_s     = sync2[WIDTH+3];
  assign par_s     = sync2[WIDTH+4];
  assign pair_s    = sync2[WIDTH+5];
  assign width_s   = sync2[WIDTH+6];

  //****************************************************************
  // Mode decode and parity
  //****************************************************************
  // The invalid setting (pair high, width low) takes the single-mode mask
  // rather than leaving the parity mask undefined.
  function automatic rbpc_mode_e mode_of(input logic pair,
                                         input logic wide);
    rbpc_mode_e m;
    m = RBPC_MODE_SINGLE;
    if (wide && !pair)
    begin
      m = RBPC_MODE_PAIR_A;
    end
    else if (wide && pair)
    begin
      m = RBPC_MODE_PAIR_B;
    end
    else if (!wide && pair)
    begin
      m = RBPC_MODE_BAD;
    end
    return m;
  endfunction : mode_of

  function automatic logic [24:0] mask_of(input rbpc_mode_e m);
    logic [24:0] k;
    k = MASK_SINGLE;
    unique case (m)
      RBPC_MODE_SINGLE: k = MASK_SINGLE;
      RBPC_MODE_PAIR_A: k = MASK_PAIR_A;
      RBPC_MODE_PAIR_B: k = MASK_PAIR_B;
      RBPC_MODE_BAD:    k = MASK_SINGLE;
    endcase
    return k;
  endfunction : mask_of

  rbpc_mode_e mode;
  logic [WIDTH-1:0] sel_mask;
  logic             hold;
  logic             data_odd;

  assign mode     = mode_of(pair_s, width_s);
  assign sel_mask = WIDTH'(mask_of(mode));
  assign hold     = cs_main_s && cs_rank_s;
  assign data_odd = ^(d_s & sel_mask);

  //****************************************************************
  // Data path through the FIFO
  //****************************************************************
  // The FIFO decouples the sink; if the sink stalls, samples stack up
  // and in_ready_o drops, which is the only back-pressure available.
  logic [WIDTH-1:0] fifo_in;
  logic             fifo_valid;
  logic [WIDTH-1:0] fifo_out;
  logic             fifo_in_ready;

  assign fifo_in = d_s;

  rbpc_fifo
  #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  )
  u_fifo
  (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (!hold),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_valid),
    .out_ready_i (out_ready_i),
    .out_data_o  (fifo_out)
  );

  // The ready flag is registered so that every output comes from a flop;
  // it therefore lags the FIFO fill level by one cycle.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      in_ready_o <= 1'h0;
    end
    else
    begin
      in_ready_o <= fifo_in_ready;
    end
  end

  // The output register loads only when the sink takes a word, so a
  // stalled sink keeps the last word standing on the pins.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_addr_out_o <= WIDTH'(DATA_RST);
    end
    else if (fifo_valid && out_ready_i)
    begin
      cmd_addr_out_o <= fifo_out;
    end
  end

  //****************************************************************
  // Ungated outputs
  //****************************************************************
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      select_out_o     <= 1'h0;
      term_ctrl_out_o  <= 1'h0;
      clk_enable_out_o <= 1'h0;
    end
    else
    begin
      select_out_o     <= cs_main_s;
      term_ctrl_out_o  <= term_s;
      clk_enable_out_o <= cke_s;
    end
  end

  //****************************************************************
  // Parity alignment and error flag
  //****************************************************************
  // The parity bit lags its data by one cycle (pair low) or two (pair
  // high), so the data parity is delayed to meet it.
  logic [1:0] odd_dly;
  logic [1:0] hold_dly;
  logic       odd_aligned;
  logic       hold_aligned;
  logic       combined;
  logic [1:0] err_cnt;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      odd_dly  <= 2'h0;
      hold_dly <= 2'h3;
    end
    else
    begin
      odd_dly  <= {odd_dly[0], data_odd};
      hold_dly <= {hold_dly[0], hold};
    end
  end

  assign odd_aligned  = pair_s ? odd_dly[1] : odd_dly[0];
  assign hold_aligned = pair_s ? hold_dly[1] : hold_dly[0];
  assign combined     = odd_aligned ^ par_s;

  // A gated sample leaves the partial parity output as it was.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      partial_parity_out_o <= PPO_RST;
    end
    else if (!hold_aligned)
    begin
      partial_parity_out_o <= combined;
    end
  end

  // A fresh error always reloads the hold count, so it wins over the count
  // running out and a persisting error keeps the flag low without a gap.
  // While the aligned sample was gated the count stands still as well, so
  // the flag and the partial parity output freeze together and a high
  // partial parity output is never seen beside a released flag.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      parity_error_n_o    <= ERR_N_RST;
      parity_error_n_oe_o <= 1'h0;
      err_cnt             <= 2'h0;
    end
    else if (hold_aligned)
    begin
      err_cnt <= err_cnt;
    end
    else if (combined)
    begin
      parity_error_n_o    <= 1'h0;
      parity_error_n_oe_o <= 1'h1;
      err_cnt             <= ERR_HOLD_CNT;
    end
    else if (err_cnt != 2'h0)
    begin
      err_cnt <= err_cnt - 2'h1;
      if (err_cnt == 2'h1)
      begin
        parity_error_n_o    <= 1'h1;
        parity_error_n_oe_o <= 1'h0;
      end
    end
  end

endmodule : rbpc_top

`default_nettype wire

// file: tb/rbpc_bench.sv
/* Bench for rbpc_top: a table of parity cases, then hand tests.
   Assumes the checker binds itself and the sink drives ready. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s expected %h seen %h", n, e, g); end end
module rbpc_bench;
  logic clock = 1'b0, rst = 1'b0, csm = 1'b0, chip_select_rank_n = 1'b0, term = 1'b0;
  logic cke = 1'b0, par = 1'b0, pair = 1'b0, width = 1'b0, stall = 1'b0;
  logic rdy, in_rdy, sel, t_o, cke_o, partial_parity_out, err_n;
  logic [24:0] cmd = 25'h0, q, prev;
  int n_errors = 0, num_checks = 0, nx;
  // Pair, width, parity bit, expected odd flag, then the data word.
  logic [28:0] rows [9] = '{29'h3000000, 29'h48, 29'h4000002, 29'ha002000,
    29'h8004000, 29'h1a000001, 29'h1a000080, 29'h18002000, 29'h13000000};
  always #25 clock = ~clock;
  rbpc_sink u_rbpc_sink (.clock_i(clock), .rst_i(rst), .stall_i(stall),
    .out_ready_o(rdy));
  rbpc_top u_rbpc_top (.clock_i(clock), .rst_i(rst), .cmd_addr_in_i(cmd),
    .chip_select_main_n_i(csm), .chip_select_rank_n_i(chip_select_rank_n),
    .term_ctrl_in_i(term), .clk_enable_in_i(cke), .parity_bit_in_i(par),
    .pair_select_cfg_i(pair), .width_select_cfg_i(width),
    .out_ready_i(rdy), .in_ready_o(in_rdy), .cmd_addr_out_o(q),
    .select_out_o(sel), .term_ctrl_out_o(t_o), .clk_enable_out_o(cke_o),
    .partial_parity_out_o(partial_parity_out), .parity_error_n_o(err_n),
    .parity_error_n_oe_o());
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask : step
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // Data floats during reset to show that it cannot leak out.
  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    cmd <= 'x;
    par <= 1'bx;
    step(2);
    @(negedge clock);
    `CHK("out", 25'h0, q)
    `CHK("ppo", 1'b0, partial_parity_out)
    `CHK("err", 1'b1, err_n)
    @(posedge clock);
    rst <= 1'b0;
    cmd <= 25'h0;
    par <= 1'b0;
    step(6);
    @(negedge clock);
    `CHK("out", 25'h0, q)
    $display("reset test done");
  endtask : do_reset
  task automatic pulse(input int lag, input logic p, input int lows);
    int seen;
    seen = 0;
    @(posedge clock);
    pair <= lag[1];
    width <= 1'b1;
    step(4);
    cmd <= 25'h2;
    for (int k = 1; k < 15; k++)
    begin
      @(posedge clock);
      cmd <= 25'h0;
      par <= p && k == lag;
      @(negedge clock);
      seen += !err_n;
    end
    `CHK("lows", lows, seen)
    $display("pulse test done");
  endtask : pulse
  // ********************************************************
  // Stimulus
  // ********************************************************
  initial
  begin
    rst <= 1'b1;
    do_reset();
    foreach (rows[i])
    begin
      @(posedge clock);
      {pair, width, par} <= rows[i][28:26];
      term <= rows[i][25];
      cke <= rows[i][0];
      cmd <= rows[i][24:0];
      step(10);
      @(negedge clock);
      `CHK("data", rows[i][24:0], q)
      `CHK("ppo", rows[i][25], partial_parity_out)
      `CHK("err", !rows[i][25], err_n)
      `CHK("term", rows[i][25], t_o)
      `CHK("cke", rows[i][0], cke_o)
      @(posedge clock);
      {par, cmd} <= 26'h0;
      step(12);
    end
    $display("table test done");
    pulse(1, 1'b1, 0);
    pulse(2, 1'b1, 0);
    pulse(1, 1'b0, 2);
    pulse(2, 1'b0, 2);
    @(posedge clock);
    cmd <= 25'h2;
    @(posedge clock);
    cmd <= 25'h0;
    for (int k = 0; k < 12 && err_n !== 1'b0; k++)
      @(negedge clock);
    `CHK("err", 1'b0, err_n)
    do_reset();
    @(posedge clock);
    {pair, width} <= 2'h0;
    cmd <= 25'h6;
    step(8);
    {csm, chip_select_rank_n, term} <= 3'h7;
    cmd <= 25'h2;
    step(10);
    @(negedge clock);
    `CHK("held", 25'h6, q)
    `CHK("ppo", 1'b0, partial_parity_out)
    `CHK("err", 1'b1, err_n)
    `CHK("sel", 1'b1, sel)
    `CHK("term", 1'b1, t_o)
    @(posedge clock);
    chip_select_rank_n <= 1'b0;
    cmd <= 25'h1100000;
    step(10);
    @(negedge clock);
    `CHK("data", 25'h1100000, q)
    `CHK("sel", 1'b1, sel)
    @(posedge clock);
    chip_select_rank_n <= 1'b1;
    step(6);
    stall <= 1'b1;
    step(3);
    chip_select_rank_n <= 1'b0;
    for (int i = 1; i < 9; i++)
    begin
      cmd <= 25'(i);
      @(posedge clock);
    end
    cmd <= 25'h0;
    step(4);
    @(negedge clock);
    `CHK("full", 1'b0, in_rdy)
    `CHK("stall", 25'h1100000, q)
    @(posedge clock);
    stall <= 1'b0;
    prev = q;
    nx = 1;
    for (int k = 0; k < 20 && nx < 5; k++)
    begin
      @(negedge clock);
      if (q !== prev)
      begin
        `CHK("drain", 25'(nx), q)
        nx++;
        prev = q;
      end
    end
    `CHK("count", 5, nx)
    $display("buffer test done");
    finish_test();
  end
  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule : rbpc_bench
`default_nettype wire

// file: tb/rbpc_chk.sv
/* Port checker for rbpc_top, bound after the module.
   Assumes one clock and an active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module rbpc_chk
#(
  parameter int unsigned WIDTH = 25
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic chip_select_main_n_i,
  input wire logic chip_select_rank_n_i,
  input wire logic term_ctrl_in_i,
  input wire logic out_ready_i,
  input wire logic [WIDTH-1:0] cmd_addr_out_o,
  input wire logic select_out_o,
  input wire logic term_ctrl_out_o,
  input wire logic partial_parity_out_o,
  input wire logic parity_error_n_o,
  input wire logic parity_error_n_oe_o
);
  // Pins seen during reset never reach outputs, so wait for the pipe.
  logic [2:0] up;
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_gated;
    (chip_select_main_n_i && chip_select_rank_n_i && out_ready_i) [*8];
  endsequence
  sel_follow_a: assert property (up == 3'h7 |->
    select_out_o == $past(chip_select_main_n_i, 3)) else $error("sel");
  term_follow_a: assert property (up == 3'h7 |->
    term_ctrl_out_o == $past(term_ctrl_in_i, 3)) else $error("term");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |->
    cmd_addr_out_o == '0 && !partial_parity_out_o && parity_error_n_o)
    else $error("reset");
  err_hold_a: assert property ($fell(parity_error_n_o) |->
    !parity_error_n_o [*2]) else $error("hold");
  err_drive_a: assert property (parity_error_n_oe_o ==
    !parity_error_n_o) else $error("drive");
  odd_flag_a: assert property (partial_parity_out_o |->
    !parity_error_n_o) else $error("odd");
  gate_data_a: assert property (s_gated |=>
    $stable(cmd_addr_out_o)) else $error("gate data");
  gate_ppo_a: assert property (s_gated |=>
    $stable(partial_parity_out_o)) else $error("gate parity");
endmodule : rbpc_chk
bind rbpc_top rbpc_chk #(.WIDTH(WIDTH)) u_rbpc_chk (.clock_i(clock_i),
  .rst_i(rst_i), .chip_select_main_n_i(chip_select_main_n_i),
  .chip_select_rank_n_i(chip_select_rank_n_i),
  .term_ctrl_in_i(term_ctrl_in_i), .out_ready_i(out_ready_i),
  .cmd_addr_out_o(cmd_addr_out_o), .select_out_o(select_out_o),
  .term_ctrl_out_o(term_ctrl_out_o),
  .partial_parity_out_o(partial_parity_out_o),
  .parity_error_n_o(parity_error_n_o),
  .parity_error_n_oe_o(parity_error_n_oe_o));
`default_nettype wire

// file: tb/rbpc_sink.sv
/* Memory-side sink model for the buffer's data output.
   Assumes the bench moves stall_i just after rising edges. */
`timescale 1ns/1ps
`default_nettype none
module rbpc_sink
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  output var  logic out_ready_o
);
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i) out_ready_o <= 1'b0;
    else out_ready_o <= !stall_i;
endmodule : rbpc_sink
`default_nettype wire
